// ---- flash_ctl_regs.svh ----
// Constants shared by both ends of the flash program/erase link.
// Assumes a single 20 MHz clock domain and is included by bare name.
`ifndef FLASH_CTL_REGS_SVH
`define FLASH_CTL_REGS_SVH

// Controller register offsets (word index on the software port)
`define OFS_CTL1        4'h0
`define OFS_CTL3        4'h1
`define OFS_CLKSEL      4'h2
`define OFS_STATUS      4'h3
`define OFS_MASK        4'h4
`define OFS_DIV         4'h5
// Control register one fields
`define CTL1_ABORT_BIT  0
`define CTL1_SUSP_BIT   1
`define CTL1_ERASE_BIT  2
`define CTL1_WRITE_BIT  3
// Control register three fields
`define CTL3_BUSY_BIT   0
`define CTL3_EMERGENCY_EXIT_BIT_BIT   1
// Status / mask fields
`define ST_DONE_BIT     0
`define ST_EXIT_BIT     1
`define ST_SUSP_BIT     2
// Reset values
`define CTL1_RESET      8'h00
`define CTL3_RESET      8'h00
`define CLKSEL_RESET    2'h0
`define DIV_RESET       8'h03
// Operation lengths in divided clock ticks
`define WRITE_TICKS     16'h0023
`define ERASE_TICKS     16'h1000
`endif

// ---- flash_ctl_pkg.sv ----
// Types shared by both ends of the flash program/erase link.
// Assumes the constants header supplies the numeric values.
package flash_ctl_pkg;
	// Timing clock sources
	typedef enum logic [1:0] {
		SRC_AUX  = 2'h0,
		SRC_SUB  = 2'h1,
		SRC_MAIN = 2'h2,
		SRC_XTAL = 2'h3
	} clk_src_t;
	// Sequencer states, Gray coded along idle-run-susp
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_RUN  = 2'b01,
		ST_SUSP = 2'b11
	} seq_state_t;
endpackage

// ---- flash_link_if.sv ----
// Link between CPU-side end and flash controller end.
// Assumes both ends share mclk; no clocking block.
interface flash_link_if;
	import flash_ctl_pkg::*;
	logic        acc_wr;     // Flash/control write strobe
	logic        acc_rd;     // Control read strobe
	logic        acc_ctl;    // 1: control register, 0: flash array
	logic [15:0] acc_addr;
	logic [15:0] acc_wdata;
	logic [15:0] acc_rdata;  // Valid the cycle after acc_rd
	logic        irq_event;  // CPU interrupt taken (pulse)
	logic        return_from_interrupt_event; // Return from interrupt executed (pulse)
	logic        global_interrupt_enable;        // Global interrupt enable level
	logic        lpm_req;    // CPU asks for low-power state
	logic        clk_hold;   // Controller holds source clock
	logic        busy;       // Operation active
	modport ctl (input acc_wr, acc_rd, acc_ctl, acc_addr, acc_wdata, irq_event, return_from_interrupt_event,
		global_interrupt_enable, lpm_req, output acc_rdata, clk_hold, busy);
	modport cpu (output acc_wr, acc_rd, acc_ctl, acc_addr, acc_wdata, irq_event, return_from_interrupt_event,
		global_interrupt_enable, lpm_req, input acc_rdata, clk_hold, busy);
endinterface

// ---- flash_ctl.sv ----
// Flash program/erase sequencer: clock source select, busy, emergency exit,
// interrupt abort and interrupt suspend of erase. Drives the flash array.
// Assumes synchronous inputs on mclk and a CPU end on flash_link_if.cpu.
//
// The address-and-strobe port and the register addresses are this design's own decisions.
`include "flash_ctl_regs.svh"
module flash_ctl #(
	parameter logic [15:0] WRITE_TICKS = `WRITE_TICKS,
	parameter logic [15:0] ERASE_TICKS = `ERASE_TICKS
) (
	// Clock and reset
	input  wire logic                    mclk,
	input  wire logic                    sys_rst,
	// Link to CPU end
	flash_link_if.ctl                    link,
	// Clock sources, as enables on mclk
	input  wire logic                    aux_clk_en,
	input  wire logic                    subsystem_clock_en,
	input  wire logic                    main_clk_en,
	input  wire logic                    xtal_clk_en,
	input  wire logic                    xtal_fault,
	// Flash array side
	output logic                         arr_prog,
	output logic                         arr_erase,
	output logic [15:0]                  arr_addr,
	output logic [15:0]                  arr_data,
	output flash_ctl_pkg::clk_src_t      src_sel,
	// Interrupt
	output logic                         irq
);
	import flash_ctl_pkg::*;

	logic [7:0]  ctl1_reg;
	logic        emergency_exit_bit_reg;
	logic [2:0]  status_reg;
	logic [2:0]  mask_reg;
	logic [7:0]  div_reg;
	logic [7:0]  div_cnt_reg;
	logic [15:0] tick_cnt_reg;
	logic        is_erase_reg;
	seq_state_t  state_reg;
	logic        src_en;
	logic        tick;
	logic        exit_req;
	logic        done;
	logic        start;
	logic [2:0]  ev;

	// Control write decode
	function automatic logic ctl_wr(input logic [3:0] ofs);
		ctl_wr = link.acc_wr && link.acc_ctl && link.acc_addr[3:0] == ofs;
	endfunction

	// Source clock enable from the selected source
	always_comb begin
		case (src_sel)
			SRC_AUX:  src_en = aux_clk_en;
			SRC_SUB:  src_en = subsystem_clock_en;
			SRC_MAIN: src_en = main_clk_en;
			SRC_XTAL: src_en = xtal_clk_en && !xtal_fault;
			default:  src_en = 1'b0;
		endcase
	end

	// Operation tick divider from source enable
	always_ff @(posedge mclk) begin
		if (sys_rst || state_reg != ST_RUN)
			div_cnt_reg <= 8'h00;
		else if (src_en)
			div_cnt_reg <= (div_cnt_reg >= div_reg) ? 8'h00 : div_cnt_reg + 8'h01;
	end
	assign tick = src_en && div_cnt_reg >= div_reg;

	assign exit_req = emergency_exit_bit_reg
		|| (link.irq_event && link.global_interrupt_enable && ctl1_reg[`CTL1_ABORT_BIT])
		|| (xtal_fault && src_sel == SRC_XTAL);
	assign done  = state_reg == ST_RUN && tick && tick_cnt_reg == 16'h0001;
	assign start = state_reg == ST_IDLE && link.acc_wr && !link.acc_ctl && !emergency_exit_bit_reg
		&& (ctl1_reg[`CTL1_ERASE_BIT] || ctl1_reg[`CTL1_WRITE_BIT]);

	// Sequencer state
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			state_reg <= ST_IDLE;
		end else begin
			case (state_reg)
				ST_IDLE: if (start) state_reg <= ST_RUN;
				ST_RUN: begin
					if (exit_req || done)
						state_reg <= ST_IDLE;
					else if (is_erase_reg && link.irq_event && ctl1_reg[`CTL1_SUSP_BIT])
						state_reg <= ST_SUSP;
				end
				ST_SUSP: begin
					if (exit_req)
						state_reg <= ST_IDLE;
					else if (link.return_from_interrupt_event)
						state_reg <= ST_RUN;
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Operation length counter and captured target
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			tick_cnt_reg <= 16'h0000;
			is_erase_reg <= 1'b0;
			arr_addr     <= 16'h0000;
			arr_data     <= 16'h0000;
		end else if (start) begin
			is_erase_reg <= ctl1_reg[`CTL1_ERASE_BIT];
			tick_cnt_reg <= ctl1_reg[`CTL1_ERASE_BIT] ? ERASE_TICKS : WRITE_TICKS;
			arr_addr     <= link.acc_addr;
			arr_data     <= link.acc_wdata;
		end else if (state_reg == ST_RUN && tick && tick_cnt_reg != 16'h0000) begin
			tick_cnt_reg <= tick_cnt_reg - 16'h0001;
		end
	end

	// Array drive, busy and clock hold follow the sequencer
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			arr_prog      <= 1'b0;
			arr_erase     <= 1'b0;
			link.busy     <= 1'b0;
			link.clk_hold <= 1'b0;
		end else begin
			arr_prog      <= (start && !ctl1_reg[`CTL1_ERASE_BIT])
				|| (state_reg == ST_RUN && !is_erase_reg && !exit_req && !done);
			arr_erase     <= (start && ctl1_reg[`CTL1_ERASE_BIT])
				|| (state_reg == ST_RUN && is_erase_reg && !exit_req && !done
				&& !(link.irq_event && ctl1_reg[`CTL1_SUSP_BIT]))
				|| (state_reg == ST_SUSP && link.return_from_interrupt_event && !exit_req);
			link.busy     <= start || (state_reg != ST_IDLE && !exit_req && !done);
			link.clk_hold <= start || (state_reg != ST_IDLE && !exit_req && !done);
		end
	end

	// Control registers written by software
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			ctl1_reg <= `CTL1_RESET;
			src_sel  <= SRC_AUX;
			mask_reg <= 3'h0;
			div_reg  <= `DIV_RESET;
		end else begin
			if (ctl_wr(`OFS_CTL1)) ctl1_reg <= link.acc_wdata[7:0];
			if (ctl_wr(`OFS_CLKSEL)) src_sel <= clk_src_t'(link.acc_wdata[1:0]);
			if (ctl_wr(`OFS_MASK)) mask_reg <= link.acc_wdata[2:0];
			if (ctl_wr(`OFS_DIV)) div_reg <= link.acc_wdata[7:0];
		end
	end

	// Emergency exit bit; stays set until software clears it
	always_ff @(posedge mclk) begin
		if (sys_rst)
			emergency_exit_bit_reg <= 1'b0;
		else if (ctl_wr(`OFS_CTL3))
			emergency_exit_bit_reg <= link.acc_wdata[`CTL3_EMERGENCY_EXIT_BIT_BIT];
	end

	// Sticky events; a read clears, a coincident event wins
	assign ev[`ST_DONE_BIT] = done;
	assign ev[`ST_EXIT_BIT] = state_reg != ST_IDLE && exit_req;
	assign ev[`ST_SUSP_BIT] = state_reg == ST_RUN && is_erase_reg && !exit_req && !done
		&& link.irq_event && ctl1_reg[`CTL1_SUSP_BIT];
	always_ff @(posedge mclk) begin
		if (sys_rst)
			status_reg <= 3'h0;
		else if (link.acc_rd && link.acc_ctl && link.acc_addr[3:0] == `OFS_STATUS)
			status_reg <= ev;
		else
			status_reg <= status_reg | ev;
	end

	// Interrupt output
	always_ff @(posedge mclk) begin
		if (sys_rst)
			irq <= 1'b0;
		else
			irq <= |((status_reg | ev) & mask_reg);
	end

	// Read data, one cycle after the strobe
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			link.acc_rdata <= 16'h0000;
		end else if (link.acc_rd && link.acc_ctl) begin
			case (link.acc_addr[3:0])
				`OFS_CTL1:   link.acc_rdata <= {8'h00, ctl1_reg};
				`OFS_CTL3:   link.acc_rdata <= {14'h0000, emergency_exit_bit_reg, link.busy};
				`OFS_CLKSEL: link.acc_rdata <= {14'h0000, src_sel};
				`OFS_STATUS: link.acc_rdata <= {13'h0000, status_reg};
				`OFS_MASK:   link.acc_rdata <= {13'h0000, mask_reg};
				`OFS_DIV:    link.acc_rdata <= {8'h00, div_reg};
				default:     link.acc_rdata <= 16'h0000;
			endcase
		end else begin
			link.acc_rdata <= 16'h0000;
		end
	end
endmodule

// ---- flash_cpu_end.sv ----
// CPU-side end: turns user requests into link accesses and interrupt events.
// Assumes the controller end on flash_link_if.ctl and one mclk domain.
`include "flash_ctl_regs.svh"
module flash_cpu_end (
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	// Link to controller
	flash_link_if.cpu        link,
	// User request port
	input  wire logic        req_wr,
	input  wire logic        req_rd,
	input  wire logic        req_ctl,
	input  wire logic [15:0] req_addr,
	input  wire logic [15:0] req_wdata,
	input  wire logic        req_irq,
	input  wire logic        req_return_from_interrupt,
	input  wire logic        req_gie,
	input  wire logic        req_lpm,
	// User answers
	output logic [15:0]      rsp_rdata,
	output logic             rsp_valid,
	output logic             lpm_active
);
	import flash_ctl_pkg::*;

	logic rd_pend_reg;

	// Forward requests to the link, registered
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			link.acc_wr     <= 1'b0;
			link.acc_rd     <= 1'b0;
			link.acc_ctl    <= 1'b0;
			link.acc_addr   <= 16'h0000;
			link.acc_wdata  <= 16'h0000;
			link.irq_event  <= 1'b0;
			link.return_from_interrupt_event <= 1'b0;
			link.global_interrupt_enable        <= 1'b0;
		end else begin
			link.acc_wr     <= req_wr;
			link.acc_rd     <= req_rd && !req_wr;
			link.acc_ctl    <= req_ctl;
			link.acc_addr   <= req_addr;
			link.acc_wdata  <= req_wdata;
			link.irq_event  <= req_irq;
			link.return_from_interrupt_event <= req_return_from_interrupt;
			link.global_interrupt_enable        <= req_gie;
		end
	end

	// Low-power entry is deferred while the controller is busy
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			link.lpm_req <= 1'b0;
			lpm_active   <= 1'b0;
		end else begin
			link.lpm_req <= req_lpm;
			lpm_active   <= req_lpm && !link.busy && !link.clk_hold;
		end
	end

	// Read answer handed back to the user
	always_ff @(posedge mclk) begin
		if (sys_rst) begin
			rd_pend_reg <= 1'b0;
			rsp_valid   <= 1'b0;
			rsp_rdata   <= 16'h0000;
		end else begin
			rd_pend_reg <= link.acc_rd; // Valid lines up with the registered read word
			rsp_valid   <= rd_pend_reg;
			rsp_rdata   <= link.acc_rdata;
		end
	end
endmodule

// ---- flash_link_sva.sv ----
// Concurrent checks on the link between the CPU end and the controller.
// Assumes one mclk domain and the offsets of the shared constants header.
`include "flash_ctl_regs.svh"
module flash_link_sva (
	// Clock and reset
	input wire logic        mclk,
	input wire logic        sys_rst,
	// Link signals
	input wire logic        acc_wr,
	input wire logic        acc_rd,
	input wire logic        acc_ctl,
	input wire logic [15:0] acc_addr,
	input wire logic [15:0] acc_wdata,
	input wire logic [15:0] acc_rdata,
	input wire logic        irq_event,
	input wire logic        global_interrupt_enable,
	input wire logic        lpm_req,
	input wire logic        clk_hold,
	input wire logic        busy
);
	timeunit 1ns;
	timeprecision 1ns;
	logic ab_reg, su_reg, er_reg, wr_reg, ex_reg;
	logic cw, fw;
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	// Control and flash write strobes
	assign cw = acc_wr && acc_ctl;
	assign fw = acc_wr && !acc_ctl;
	// Shadow of the option bits
	always_ff @(posedge mclk) begin
		if (sys_rst)
			{wr_reg, er_reg, su_reg, ab_reg} <= 4'h0;
		else if (cw && acc_addr[3:0] == `OFS_CTL1)
			{wr_reg, er_reg, su_reg, ab_reg} <= acc_wdata[3:0];
	end
	// Shadow of the sticky exit bit
	always_ff @(posedge mclk) begin
		if (sys_rst)
			ex_reg <= 1'b0;
		else if (cw && acc_addr[3:0] == `OFS_CTL3)
			ex_reg <= acc_wdata[`CTL3_EMERGENCY_EXIT_BIT_BIT];
	end
	// Interrupt taken during an erase with suspend chosen, then held
	sequence s_irq_erase;
		busy && irq_event && su_reg && er_reg && !(ab_reg && global_interrupt_enable);
	endsequence
	sequence s_held;
		busy [*4];
	endsequence
	AST_HOLD: assert property (busy |-> clk_hold) else $error("clock not held while busy");
	AST_RELEASE: assert property ($fell(busy) |-> !clk_hold) else $error("clock hold kept");
	AST_START: assert property (fw && !busy && !ex_reg && (wr_reg || er_reg) |-> ##1 busy)
		else $error("operation did not start");
	AST_ONLY_ON_WRITE: assert property ($rose(busy) |-> $past(fw)) else $error("busy without write");
	AST_EMERGENCY_EXIT_BIT: assert property (cw && acc_addr[3:0] == `OFS_CTL3 && acc_wdata[1] |-> ##[1:2] !busy)
		else $error("exit bit did not stop operation");
	AST_ABORT: assert property (busy && irq_event && global_interrupt_enable && ab_reg |-> ##[1:2] !busy)
		else $error("interrupt did not abort");
	AST_SUSPEND: assert property (s_irq_erase |=> s_held) else $error("suspended erase lost busy");
	AST_BUSY_BIT: assert property (acc_rd && acc_ctl && acc_addr[3:0] == `OFS_CTL3 |=>
		acc_rdata[`CTL3_BUSY_BIT] == $past(busy)) else $error("busy bit wrong");
	AST_RDATA_IDLE: assert property (!acc_rd |=> acc_rdata == 16'h0000) else $error("stale read data");
	AST_LPM_RELEASE: assert property (lpm_req && !busy |-> !clk_hold) else $error("clock held in low power");
endmodule

// ---- flash_program_erase_control_bench.sv ----
// Bench for the flash controller facing its CPU end over the link.
// Assumes both ends on flash_link_if; link stimulus on the user side, clock enables and xtal_fault driven directly.
`include "flash_ctl_regs.svh"
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin n_errors++; $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module flash_program_erase_control_bench;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {logic w; logic [3:0] a; logic [15:0] d;} row_t;
	logic                    mclk = 1'b0;
	logic                    sys_rst = 1'b1;
	logic                    req_wr, req_rd, req_ctl, req_irq, req_return_from_interrupt, req_gie, req_lpm;
	logic                    aux_clk_en, subsystem_clock_en, main_clk_en, xtal_clk_en, xtal_fault;
	logic [15:0]             req_addr, req_wdata, q, rsp_rdata, arr_addr, arr_data;
	logic                    rsp_valid, lpm_active, arr_prog, arr_erase, irq;
	flash_ctl_pkg::clk_src_t src_sel;
	int                      n_errors = 0;
	int                      cmp_count = 0;
	int                      cyc = 0;
	row_t rows [9] = '{'{1'b0, `OFS_CTL1, 16'h0000}, '{1'b0, `OFS_CTL3, 16'h0000}, '{1'b0, `OFS_CLKSEL, 16'h0000},
		'{1'b0, `OFS_DIV, 16'h0003}, '{1'b1, `OFS_CLKSEL, 16'h0001}, '{1'b0, `OFS_CLKSEL, 16'h0001},
		'{1'b1, `OFS_CLKSEL, 16'h0000}, '{1'b0, 4'hf, 16'h0000}, '{1'b1, `OFS_MASK, 16'h0007}};
	flash_link_if link ();
	flash_ctl #(.WRITE_TICKS(16'h0004), .ERASE_TICKS(16'h0008)) i_flash_ctl (.mclk, .sys_rst, .link(link),
		.aux_clk_en, .subsystem_clock_en, .main_clk_en, .xtal_clk_en, .xtal_fault,
		.arr_prog, .arr_erase, .arr_addr, .arr_data, .src_sel, .irq);
	flash_cpu_end i_flash_cpu_end (.mclk, .sys_rst, .link(link), .req_wr, .req_rd, .req_ctl, .req_addr,
		.req_wdata, .req_irq, .req_return_from_interrupt, .req_gie, .req_lpm, .rsp_rdata, .rsp_valid, .lpm_active);
	flash_link_sva i_flash_link_sva (.mclk, .sys_rst, .acc_wr(link.acc_wr), .acc_rd(link.acc_rd),
		.acc_ctl(link.acc_ctl), .acc_addr(link.acc_addr), .acc_wdata(link.acc_wdata),
		.acc_rdata(link.acc_rdata), .irq_event(link.irq_event), .global_interrupt_enable(link.global_interrupt_enable),
		.lpm_req(link.lpm_req), .clk_hold(link.clk_hold), .busy(link.busy));
	// Clock and hang guard
	always #25 mclk = ~mclk;
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 20000) begin
			n_errors++;
			conclude();
		end
	end
	// One access; read data land in q
	task acc(input logic w, input logic c, input logic [15:0] a, input logic [15:0] d);
		@(posedge mclk);
		req_wr <= w;
		req_rd <= !w;
		req_ctl <= c;
		req_addr <= a;
		req_wdata <= d;
		@(posedge mclk);
		req_wr <= 1'b0;
		req_rd <= 1'b0;
		q = 'x;
		repeat (5) @(negedge mclk) if (rsp_valid === 1'b1) q = rsp_rdata;
	endtask
	task wreg(input logic [3:0] o, input logic [15:0] d);
		acc(1'b1, 1'b1, {12'h000, o}, d);
	endtask
	task rreg(input logic [3:0] o);
		acc(1'b0, 1'b1, {12'h000, o}, 16'h0000);
	endtask
	// Interrupt taken (0) or return executed (1)
	task ev(input logic r);
		@(posedge mclk);
		if (r) req_return_from_interrupt <= 1'b1;
		else req_irq <= 1'b1;
		@(posedge mclk);
		req_return_from_interrupt <= 1'b0;
		req_irq <= 1'b0;
	endtask
	task waitb(input logic v);
		int n;
		n = 0;
		while (link.busy !== v && n < 300) begin
			@(negedge mclk);
			n++;
		end
		`CHK("wait", v, link.busy)
	endtask
	task conclude;
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	// Main sequence
	initial begin
		{req_wr, req_rd, req_ctl, req_irq, req_return_from_interrupt, req_gie, req_lpm, xtal_fault} = 8'h00;
		{aux_clk_en, subsystem_clock_en, main_clk_en, xtal_clk_en} = 4'hf;
		req_addr = 16'h0000;
		req_wdata = 16'h0000;
		repeat (6) @(posedge mclk);
		sys_rst <= 1'b0;
		foreach (rows[i]) begin
			if (rows[i].w) wreg(rows[i].a, rows[i].d);
			else begin
				rreg(rows[i].a);
				`CHK("row", rows[i].d, q)
			end
		end
		// Plain write, busy bit, completion event and interrupt
		wreg(`OFS_CTL1, 16'h0008);
		acc(1'b1, 1'b0, 16'h1234, 16'hbeef);
		`CHK("prog", 1'b1, arr_prog)
		`CHK("data", 16'hbeef, arr_data)
		`CHK("addr", 16'h1234, arr_addr)
		rreg(`OFS_CTL3);
		`CHK("busybit", 1'b1, q[`CTL3_BUSY_BIT])
		waitb(1'b0);
		repeat (2) @(negedge mclk);
		`CHK("hold", 1'b0, link.clk_hold)
		`CHK("irq", 1'b1, irq)
		rreg(`OFS_STATUS);
		`CHK("done", 1'b1, q[`ST_DONE_BIT])
		`CHK("irqclr", 1'b0, irq)
		// Low power asked while busy, interrupt masked
		wreg(`OFS_MASK, 16'h0000);
		acc(1'b1, 1'b0, 16'h1236, 16'h0001);
		@(posedge mclk) req_lpm <= 1'b1;
		repeat (2) @(negedge mclk);
		`CHK("lpm", 1'b0, lpm_active)
		`CHK("hold", 1'b1, link.clk_hold)
		waitb(1'b0);
		repeat (3) @(negedge mclk);
		`CHK("lpm", 1'b1, lpm_active)
		`CHK("irqmask", 1'b0, irq)
		@(posedge mclk) req_lpm <= 1'b0;
		wreg(`OFS_MASK, 16'h0007);
		rreg(`OFS_STATUS);
		// Exit bit during erase, then a refused write
		wreg(`OFS_CTL1, 16'h0004);
		acc(1'b1, 1'b0, 16'h2000, 16'h0000);
		wreg(`OFS_CTL3, 16'h0002);
		`CHK("busy", 1'b0, link.busy)
		`CHK("erase", 1'b0, arr_erase)
		acc(1'b1, 1'b0, 16'h2000, 16'h0000);
		`CHK("refused", 1'b0, link.busy)
		rreg(`OFS_STATUS);
		`CHK("exit", 1'b1, q[`ST_EXIT_BIT])
		wreg(`OFS_CTL3, 16'h0000);
		repeat (20) @(posedge mclk);
		// Abort option: ignored with interrupts off, taken with them on
		wreg(`OFS_CTL1, 16'h0005);
		for (int g = 0; g < 2; g++) begin
			@(posedge mclk) req_gie <= g[0];
			acc(1'b1, 1'b0, 16'h2200, 16'h0000);
			ev(1'b0);
			repeat (2) @(negedge mclk);
			`CHK("abort", !g[0], link.busy)
			waitb(1'b0);
		end
		rreg(`OFS_STATUS);
		`CHK("exit", 1'b1, q[`ST_EXIT_BIT])
		// Suspend an erase, stay suspended, resume on return
		wreg(`OFS_CTL1, 16'h0006);
		acc(1'b1, 1'b0, 16'h2400, 16'h0000);
		ev(1'b0);
		repeat (40) @(negedge mclk);
		`CHK("susp", 2'b10, {link.busy, arr_erase})
		ev(1'b1);
		repeat (2) @(negedge mclk);
		`CHK("resume", 1'b1, arr_erase)
		waitb(1'b0);
		rreg(`OFS_STATUS);
		`CHK("suspbit", 1'b1, q[`ST_SUSP_BIT])
		// Crystal source fails mid-write
		wreg(`OFS_CLKSEL, 16'h0003);
		`CHK("src", flash_ctl_pkg::SRC_XTAL, src_sel)
		wreg(`OFS_CTL1, 16'h0008);
		acc(1'b1, 1'b0, 16'h1300, 16'h00a5);
		@(posedge mclk) xtal_fault <= 1'b1;
		repeat (3) @(negedge mclk);
		`CHK("fault", 2'b00, {link.busy, arr_prog})
		@(posedge mclk) xtal_fault <= 1'b0;
		// Main clock selected but stopped: the write must stall
		wreg(`OFS_CLKSEL, 16'h0002);
		@(posedge mclk) main_clk_en <= 1'b0;
		acc(1'b1, 1'b0, 16'h1304, 16'h005a);
		repeat (30) @(negedge mclk);
		`CHK("stall", 1'b1, link.busy)
		@(posedge mclk) main_clk_en <= 1'b1;
		waitb(1'b0);
		// Reset in mid-operation
		wreg(`OFS_CLKSEL, 16'h0000);
		acc(1'b1, 1'b0, 16'h1302, 16'h0001);
		@(posedge mclk) sys_rst <= 1'b1;
		repeat (2) @(posedge mclk);
		sys_rst <= 1'b0;
		rreg(`OFS_CTL1);
		`CHK("rst", 17'h00000, {link.busy, q})
		conclude();
	end
endmodule
